// ### start_sequencer_defs.vh
// Constants for the motor start sequencer
`ifndef START_SEQUENCER_DEFS_VH
`define START_SEQUENCER_DEFS_VH

// Sequencer states
`define SEQ_POWER_ON     4'h0
`define SEQ_SPEED_PROBE  4'h1
`define SEQ_BRAKE        4'h2
`define SEQ_REVERSE      4'h3
`define SEQ_ALIGN        4'h4
`define SEQ_PROBE        4'h5
`define SEQ_ACCEL        4'h6
`define SEQ_CLOSED       4'h7

// Drive modes shown on drive_mode
`define DRV_OFF          3'h0
`define DRV_BRAKE        3'h1
`define DRV_ALIGN        3'h2
`define DRV_PROBE        3'h3
`define DRV_OPEN_LOOP    3'h4
`define DRV_FEEDBACK     3'h5
`define DRV_REVERSE      3'h6

// Timing: clock and base tick
`define CLK_PERIOD_NS    8
`define TICK_US          10
`define TICK_CYCLES      ((`TICK_US * 1000) / `CLK_PERIOD_NS)

// Back-emf code fields
`define BACK_EMF_MANT_MSB    3
`define BACK_EMF_SHIFT_MSB   6
`define BACK_EMF_SHIFT_LSB   4

// Probe phase pairs, drive code {u,v,w high/low}
`define PAIR_COUNT       6

`endif

// ### back_emf_constant_decoder.v
// Decoder for the 7-bit back-emf constant code
`default_nettype none
`include "start_sequencer_defs.vh"

module back_emf_constant_decoder (
    input wire [6:0] back_emf_constant_code,
    output wire [10:0] back_emf_constant_value
);
    // Mantissa in the low bits shifted by the upper three bits
    // 0x7F gives 15<<7 = 1920, 0x01 gives 1
    assign back_emf_constant_value = {7'h00, back_emf_constant_code[`BACK_EMF_MANT_MSB:0]}
        << back_emf_constant_code[`BACK_EMF_SHIFT_MSB:`BACK_EMF_SHIFT_LSB];
endmodule // back_emf_constant_decoder

`default_nettype wire

// ### start_sequencer.v
// Motor start sequencer for a sensorless three-phase drive
//
// Overview of operation
// - Back-emf code value is low four bits shifted left by upper three bits.
// - Code 0x7F decodes to the largest value, 1920.
// - Code 0x01 decodes to the value one.
// - Sequencer restarts at power-on after reset or leaving standby.
// - From power-on, speed probe if enabled, else brake decision.
// - Speed under stationary threshold goes to brake decision, else direction.
// - Forward rotation resynchronises into closed loop; reverse checks speed limit.
// - Reverse speed over limit returns to speed probe, else checks reverse enable.
// - Reverse drive enabled enters reverse drive, else brake decision.
// - Reverse drive pushes forward until zero speed, then accelerates.
// - Brake is enabled whenever brake duration setting is nonzero.
// - Brake is held for the set duration, then probe decision.
// - Nonzero probe current threshold selects probe, otherwise align.
// - Align finished leads to accelerate.
// - Probe finished leads to accelerate.
// - Accelerate ramps open loop with the two acceleration settings.
// - Closed loop entered once rate exceeds open-to-closed threshold.
// - Closed loop drives from commutation feedback, not the ramp.
// - Direction pin change stops drive and restarts from power-on.
// - Brake turns on all three low-side transistors.
// - Align drives current into V and out of W for align duration.
// - Stationary when no UV rise (nor UW rise before the first UV rise) comes within the threshold time.
// - Probe pulses VW, WV, UV, VU, WU, UW; shortest time gives position.
`default_nettype none
`include "start_sequencer_defs.vh"

module start_sequencer #(
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter PROBE_TIMEOUT = 16'hFFFF
) (
    input wire sys_clk,
    input wire rstn,
    input wire standby_exit,
    input wire dir_pin,
    input wire cmp_uv,
    input wire cmp_uw,
    input wire probe_current_hit,
    input wire feedback_active,
    input wire [5:0] feedback_gates,
    input wire speed_probe_enable,
    input wire [1:0] stationary_speed_threshold,
    input wire [2:0] reverse_speed_limit,
    input wire reverse_drive_enable,
    input wire [2:0] brake_duration_setting,
    input wire [3:0] probe_current_threshold,
    input wire [2:0] align_duration,
    input wire [2:0] startup_accel_rate_a,
    input wire [2:0] startup_accel_rate_b,
    input wire [4:0] open_to_closed_threshold,
    input wire [6:0] back_emf_constant_code,
    output reg [3:0] seq_state,
    output reg [2:0] drive_mode,
    output reg [5:0] gate_drive,
    output reg [2:0] rotor_sector,
    output reg [15:0] commutation_rate,
    output reg [10:0] back_emf_constant_value
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [3:0] meta_r;
    reg [3:0] sync_r;
    // Free-running, so the edge detectors see real pin levels at release
    always @(posedge sys_clk) begin
        meta_r <= {dir_pin, cmp_uv, cmp_uw, probe_current_hit};
        sync_r <= meta_r;
    end
    wire dir_s = sync_r[3];
    wire uv_s = sync_r[2];
    wire uw_s = sync_r[1];
    wire hit_s = sync_r[0];

    reg dir_q_r;
    reg uv_q_r;
    reg uw_q_r;
    always @(posedge sys_clk) begin
        if (!rstn) begin
            // Load the pin levels so no false edge follows reset
            dir_q_r <= dir_s;
            uv_q_r <= uv_s;
            uw_q_r <= uw_s;
        end else begin
            dir_q_r <= dir_s;
            uv_q_r <= uv_s;
            uw_q_r <= uw_s;
        end
    end
    reg dir_valid_r;
    wire dir_change = dir_valid_r && (dir_s != dir_q_r);
    wire uv_rise = uv_s && !uv_q_r;
    wire uw_rise = uw_s && !uw_q_r;

    ////////////////////////////////////////////////////////////////////////////
    // Base tick divider
    reg [15:0] div_r;
    wire tick = (div_r == TICK_CYCLES[15:0] - 16'h0001);
    always @(posedge sys_clk) begin
        if (!rstn || tick)
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Back-emf constant decode
    wire [10:0] back_emf_dec;
    back_emf_constant_decoder u_back_emf (
        .back_emf_constant_code(back_emf_constant_code),
        .back_emf_constant_value(back_emf_dec)
    );
    always @(posedge sys_clk) begin
        if (!rstn)
            back_emf_constant_value <= 11'h000;
        else
            back_emf_constant_value <= back_emf_dec;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions
    // Ticks for a 3-bit duration code: 64 << code
    function [15:0] dur_ticks;
        input [2:0] code;
        begin
            dur_ticks = 16'h0040 << code;
        end
    endfunction

    // Gate pattern {uh,vh,wh,ul,vl,wl} for a probe pair index
    function [5:0] pair_gates;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: pair_gates = 6'b010_001; // VW
                3'h1: pair_gates = 6'b001_010; // WV
                3'h2: pair_gates = 6'b100_010; // UV
                3'h3: pair_gates = 6'b010_100; // VU
                3'h4: pair_gates = 6'b001_100; // WU
                3'h5: pair_gates = 6'b100_001; // UW
                default: pair_gates = 6'b000_000;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Main state machine
    localparam S_POWER_ON = `SEQ_POWER_ON;
    localparam S_SPEED_PROBE = `SEQ_SPEED_PROBE;
    localparam S_BRAKE = `SEQ_BRAKE;
    localparam S_REVERSE = `SEQ_REVERSE;
    localparam S_ALIGN = `SEQ_ALIGN;
    localparam S_PROBE = `SEQ_PROBE;
    localparam S_ACCEL = `SEQ_ACCEL;
    localparam S_CLOSED = `SEQ_CLOSED;

    reg [15:0] timer_r;      // ticks in state
    reg [15:0] period_r;     // measured comparator period in ticks
    reg have_edge_r;
    reg forward_r;
    reg [2:0] pair_r;
    reg pulse_on_r;
    reg [15:0] pulse_cnt_r;
    reg [15:0] best_cnt_r;
    reg [7:0] ramp_div_r;

    // Speed limits: period must be shorter than a threshold-derived count
    wire [15:0] stationary_ticks = 16'h0100 << stationary_speed_threshold;
    wire [15:0] reverse_ticks = 16'h0800 >> reverse_speed_limit;
    wire [15:0] closed_rate = {6'h00, open_to_closed_threshold, 5'h00};
    wire brake_on = (brake_duration_setting != 3'h0);
    wire probe_on = (probe_current_threshold != 4'h0);

    // Decision chain after the speed-dependent stages
    wire [3:0] after_brake_dec = probe_on ? S_PROBE : S_ALIGN;
    wire [3:0] brake_dec = brake_on ? S_BRAKE : after_brake_dec;

    always @(posedge sys_clk) begin
        if (!rstn || standby_exit || dir_change) begin
            // Drive stops and the sequence restarts at power-on
            seq_state <= S_POWER_ON;
            timer_r <= 16'h0000;
            period_r <= 16'h0000;
            have_edge_r <= 1'b0;
            forward_r <= 1'b0;
            pair_r <= 3'h0;
            pulse_on_r <= 1'b0;
            pulse_cnt_r <= 16'h0000;
            best_cnt_r <= 16'hFFFF;
            rotor_sector <= 3'h0;
            commutation_rate <= 16'h0000;
            ramp_div_r <= 8'h00;
            dir_valid_r <= rstn && !standby_exit;
        end else begin
            dir_valid_r <= 1'b1;
            if (tick)
                timer_r <= timer_r + 16'h0001;
            case (seq_state)
                S_POWER_ON: begin
                    timer_r <= 16'h0000;
                    have_edge_r <= 1'b0;
                    seq_state <= speed_probe_enable ? S_SPEED_PROBE : brake_dec;
                end
                S_SPEED_PROBE: begin
                    if (uv_rise) begin
                        // Period between rising edges; direction from UW level
                        if (have_edge_r) begin
                            period_r <= timer_r;
                            forward_r <= !uw_s;
                            if (timer_r < stationary_ticks) begin
                                if (!uw_s) begin
                                    seq_state <= S_CLOSED;
                                end else if (timer_r < reverse_ticks) begin
                                    seq_state <= S_SPEED_PROBE;
                                end else if (reverse_drive_enable) begin
                                    seq_state <= S_REVERSE;
                                end else begin
                                    seq_state <= brake_dec;
                                end
                            end
                        end
                        have_edge_r <= 1'b1;
                        timer_r <= 16'h0000;
                    end else if (uw_rise && !have_edge_r) begin
                        // UW rise restarts the still window until the first UV rise
                        timer_r <= 16'h0000;
                    end else if (timer_r >= stationary_ticks) begin
                        seq_state <= brake_dec;
                        timer_r <= 16'h0000;
                    end
                end
                S_REVERSE: begin
                    // Forward drive until the comparators go quiet
                    if (uv_rise || uw_rise)
                        timer_r <= 16'h0000;
                    else if (timer_r >= stationary_ticks) begin
                        seq_state <= S_ACCEL;
                        timer_r <= 16'h0000;
                    end
                end
                S_BRAKE: begin
                    if (timer_r >= dur_ticks(brake_duration_setting)) begin
                        seq_state <= after_brake_dec;
                        timer_r <= 16'h0000;
                    end
                end
                S_ALIGN: begin
                    if (timer_r >= dur_ticks(align_duration)) begin
                        seq_state <= S_ACCEL;
                        rotor_sector <= 3'h0;
                        timer_r <= 16'h0000;
                    end
                end
                S_PROBE: begin
                    // Pulse each pair, keep the pair that hits fastest
                    if (!pulse_on_r) begin
                        // Next pulse waits until the last hit has cleared
                        pulse_on_r <= !hit_s;
                        pulse_cnt_r <= 16'h0000;
                    end else if (hit_s || pulse_cnt_r == PROBE_TIMEOUT[15:0]) begin
                        pulse_on_r <= 1'b0;
                        if (hit_s && pulse_cnt_r < best_cnt_r) begin
                            best_cnt_r <= pulse_cnt_r;
                            rotor_sector <= pair_r;
                        end
                        if (pair_r == `PAIR_COUNT - 1) begin
                            seq_state <= S_ACCEL;
                            timer_r <= 16'h0000;
                        end else begin
                            pair_r <= pair_r + 3'h1;
                        end
                    end else begin
                        pulse_cnt_r <= pulse_cnt_r + 16'h0001;
                    end
                end
                S_ACCEL: begin
                    // Open-loop ramp: rate a early, rate b later
                    if (tick) begin
                        ramp_div_r <= ramp_div_r + 8'h01;
                        commutation_rate <= commutation_rate + {13'h0000,
                            (commutation_rate[15:8] == 8'h00) ?
                            startup_accel_rate_a : startup_accel_rate_b} + 16'h0001;
                        if (ramp_div_r[3:0] == 4'hF)
                            rotor_sector <= (rotor_sector == 3'h5) ? 3'h0
                                : rotor_sector + 3'h1;
                    end
                    if (commutation_rate > closed_rate)
                        seq_state <= S_CLOSED;
                end
                S_CLOSED: begin
                    seq_state <= S_CLOSED;
                end
                default: begin
                    seq_state <= S_POWER_ON;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate drive {uh,vh,wh,ul,vl,wl}
    reg [5:0] gates_nxt;
    reg [2:0] mode_nxt;
    always @* begin
        gates_nxt = 6'b000_000;
        mode_nxt = `DRV_OFF;
        case (seq_state)
            S_BRAKE: begin
                gates_nxt = 6'b000_111;
                mode_nxt = `DRV_BRAKE;
            end
            S_ALIGN: begin
                gates_nxt = 6'b010_001;
                mode_nxt = `DRV_ALIGN;
            end
            S_PROBE: begin
                gates_nxt = pulse_on_r ? pair_gates(pair_r) : 6'b000_000;
                mode_nxt = `DRV_PROBE;
            end
            S_REVERSE: begin
                gates_nxt = pair_gates(3'h0);
                mode_nxt = `DRV_REVERSE;
            end
            S_ACCEL: begin
                gates_nxt = pair_gates(rotor_sector);
                mode_nxt = `DRV_OPEN_LOOP;
            end
            S_CLOSED: begin
                gates_nxt = feedback_active ? feedback_gates : 6'b000_000;
                mode_nxt = `DRV_FEEDBACK;
            end
            default: begin
                gates_nxt = 6'b000_000;
                mode_nxt = `DRV_OFF;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rstn || dir_change || standby_exit) begin
            gate_drive <= 6'b000_000;
            drive_mode <= `DRV_OFF;
        end else begin
            gate_drive <= gates_nxt;
            drive_mode <= mode_nxt;
        end
    end
endmodule // start_sequencer

`default_nettype wire

// ### seq_checker_properties.sv
// Concurrent checks on the start sequencer ports
`default_nettype none
module seq_checker (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic speed_probe_enable,
    input wire logic reverse_drive_enable,
    input wire logic [2:0] brake_duration_setting,
    input wire logic [3:0] probe_current_threshold,
    input wire logic [6:0] back_emf_constant_code,
    input wire logic [3:0] seq_state,
    input wire logic [2:0] drive_mode,
    input wire logic [5:0] gate_drive,
    input wire logic [10:0] back_emf_constant_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_reset_clears: assert property (disable iff (1'b0) !rstn |=> seq_state == 4'h0)
        else $error("state not cleared by reset");
    a_back_emf_decode: assert property (rstn && $past(rstn) |-> back_emf_constant_value ==
        (11'($past(back_emf_constant_code[3:0])) << $past(back_emf_constant_code[6:4])))
        else $error("back-emf value wrong");
    a_poweron_exit: assert property ($past(seq_state) == 4'h0 && seq_state != 4'h0
        |-> (seq_state == 4'h1) == speed_probe_enable) else $error("bad power-on exit");
    a_brake_entry: assert property ($changed(seq_state) && seq_state == 4'h2
        |-> brake_duration_setting != 3'h0) else $error("brake with zero duration");
    a_brake_lowside: assert property (seq_state == 4'h2 && $past(seq_state) == 4'h2
        |-> gate_drive == 6'h07) else $error("brake gates wrong");
    a_brake_exit: assert property ($past(seq_state) == 4'h2 && seq_state != 4'h2
        |-> seq_state inside {4'h0, 4'h4, 4'h5}) else $error("bad brake exit");
    a_probe_select: assert property ($changed(seq_state) && seq_state inside {4'h4, 4'h5}
        |-> (seq_state == 4'h5) == (probe_current_threshold != 4'h0)) else $error("bad init pick");
    a_align_gates: assert property (seq_state == 4'h4 && $past(seq_state) == 4'h4
        |-> gate_drive == 6'h11) else $error("align gates wrong");
    a_reverse_entry: assert property ($changed(seq_state) && seq_state == 4'h3
        |-> reverse_drive_enable) else $error("reverse drive while disabled");
    a_accel_entry: assert property ($changed(seq_state) && seq_state == 4'h6
        |-> $past(seq_state) inside {4'h3, 4'h4, 4'h5}) else $error("bad accel entry");
    a_closed_entry: assert property ($changed(seq_state) && seq_state == 4'h7
        |-> $past(seq_state) inside {4'h1, 4'h6}) else $error("bad closed entry");
    a_mode_follows: assert property (seq_state == 4'h7 && $past(seq_state) == 4'h7
        |-> drive_mode == 3'h5) else $error("closed loop mode wrong");
    a_open_loop: assert property (seq_state == 4'h6 && $past(seq_state) == 4'h6
        |-> drive_mode == 3'h4) else $error("accel mode wrong");
    a_restart_idle: assert property (seq_state == 4'h0 |-> gate_drive == 6'h00
        && drive_mode == 3'h0) else $error("drive not stopped at power-on");
endmodule // seq_checker
`default_nettype wire

// ### motor_model.sv
// Behavioural motor and power stage seen through comparators and current sense
`default_nettype none
module motor_model #(
    parameter int FAST = 3
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [1:0] spin,
    input wire logic [7:0] step_len,
    input wire logic [5:0] gate_drive,
    output logic cmp_uv,
    output logic cmp_uw,
    output logic probe_current_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    int tk = 0;
    int ph = 0;
    int pulse = 0;
    int on = 0;
    // Six electrical steps; a still motor freezes the comparators
    always @(posedge sys_clk) begin
        if (spin == 2'h0) begin
            tk <= 0;
        end else if (tk + 1 >= step_len) begin
            tk <= 0;
            ph <= (ph + 1) % 6;
        end else begin
            tk <= tk + 1;
        end
        if (!rstn) begin
            pulse <= 0;
        end else if (gate_drive == 6'h00 && on != 0) begin
            pulse <= pulse + 1;
        end
        on <= (gate_drive == 6'h00) ? 0 : on + 1;
    end
    assign cmp_uv = ph < 3;
    assign cmp_uw = (spin == 2'h2) ? (ph >= 5 || ph < 2) : (ph >= 1 && ph < 4);
    // One pair of the six rises fastest, marking the rotor position
    assign probe_current_hit = on >= ((pulse % 6 == FAST) ? 4 : 10);
endmodule // motor_model
`default_nettype wire

// ### tb_start_sequencer.sv
// Self-checking bench for the motor start sequencer
`default_nettype none
module tb_start_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rstn = 0, standby_exit = 0, dir_pin = 0, feedback_active = 1;
    logic speed_probe_enable = 0, reverse_drive_enable = 0, saw_accel = 0;
    logic [1:0] stationary_speed_threshold = 2'h0, spin = 2'h0;
    logic [2:0] reverse_speed_limit = 3'h0, brake_duration_setting = 3'h0, align_duration = 3'h0;
    logic [2:0] startup_accel_rate_a = 3'h0, startup_accel_rate_b = 3'h0;
    logic [3:0] probe_current_threshold = 4'h0;
    logic [4:0] open_to_closed_threshold = 5'h0;
    logic [5:0] feedback_gates = 6'h21;
    logic [6:0] back_emf_constant_code = 7'h00;
    logic [7:0] step_len = 8'h28;
    wire cmp_uv, cmp_uw, probe_current_hit;
    wire [3:0] seq_state;
    wire [2:0] drive_mode, rotor_sector;
    wire [5:0] gate_drive;
    wire [15:0] commutation_rate;
    wire [10:0] back_emf_constant_value;
    int num_errors = 0, checked = 0, n = 0, bad;
    always #4 sys_clk = ~sys_clk;
    start_sequencer #(.TICK_CYCLES(2), .PROBE_TIMEOUT(16'h0010)) DUT (.sys_clk, .rstn,
        .standby_exit, .dir_pin, .cmp_uv, .cmp_uw, .probe_current_hit, .feedback_active,
        .feedback_gates, .speed_probe_enable, .stationary_speed_threshold, .reverse_speed_limit,
        .reverse_drive_enable, .brake_duration_setting, .probe_current_threshold,
        .align_duration, .startup_accel_rate_a, .startup_accel_rate_b,
        .open_to_closed_threshold, .back_emf_constant_code, .seq_state, .drive_mode, .gate_drive,
        .rotor_sector, .commutation_rate, .back_emf_constant_value);
    motor_model #(.FAST(3)) motor (.sys_clk, .rstn, .spin, .step_len, .gate_drive, .cmp_uv,
        .cmp_uw, .probe_current_hit);
    task summarize;
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reset with a new configuration; ramp settings vary from run to run
    task go(input logic sp, rev, input logic [2:0] brk, input logic [3:0] inductive_position_probe,
            input logic [2:0] lim, input logic [1:0] sm, input logic [7:0] sl);
        @(negedge sys_clk);
        rstn = 0;
        {speed_probe_enable, reverse_drive_enable, brake_duration_setting} = {sp, rev, brk};
        {probe_current_threshold, reverse_speed_limit, spin, step_len} = {inductive_position_probe, lim, sm, sl};
        n = n + 1;
        startup_accel_rate_a = 3'(n);
        startup_accel_rate_b = 3'(n + 1);
        open_to_closed_threshold = 5'(n * 3);
        align_duration = 3'(n % 2);
        saw_accel = 0;
        repeat (8) @(negedge sys_clk);
        rstn = 1;
    endtask
    task wait_st(input logic [3:0] want, input int lim);
        int k;
        k = 0;
        while (seq_state !== want && k < lim) begin
            @(negedge sys_clk);
            if (seq_state === 4'h6) saw_accel = 1;
            k++;
        end
        chk(seq_state, want);
    endtask
    initial begin
        #700us;
        num_errors++;
        summarize();
    end
    initial begin
        go(0, 0, 3'h1, 4'h0, 3'h0, 2'h0, 8'h28);
        for (int i = 0; i < 128; i++) begin
            back_emf_constant_code = 7'(i);
            @(negedge sys_clk);
            chk(back_emf_constant_value, 11'(i % 16) << (i / 16));
            if (i == 1 || i == 127) chk(back_emf_constant_value, (i == 1) ? 1 : 1920);
        end
        // Host value for 1.76 V/Hz scaled by 1090 is near 1920, code 0x7F
        back_emf_constant_code = 7'h7F;
        @(negedge sys_clk);
        chk(back_emf_constant_value, 16'h0780);
        go(0, 0, 3'h1, 4'h0, 3'h0, 2'h0, 8'h28);
        wait_st(4'h2, 20);
        repeat (3) @(negedge sys_clk);
        chk(gate_drive, 6'h07);
        wait_st(4'h4, 600);
        repeat (3) @(negedge sys_clk);
        chk(gate_drive, 6'h11);
        wait_st(4'h6, 600);
        @(negedge sys_clk);
        chk(drive_mode, 3'h4);
        wait_st(4'h7, 5000);
        chk(16'(commutation_rate > {open_to_closed_threshold, 5'h00}), 16'h0001);
        repeat (3) @(negedge sys_clk);
        chk(gate_drive, feedback_gates);
        dir_pin = ~dir_pin;
        wait_st(4'h2, 12);
        go(0, 0, 3'h0, 4'h5, 3'h0, 2'h0, 8'h28);
        wait_st(4'h5, 20);
        wait_st(4'h6, 2000);
        chk(rotor_sector, 3'h3);
        standby_exit = 1;
        @(negedge sys_clk);
        standby_exit = 0;
        wait_st(4'h5, 12);
        go(1, 0, 3'h0, 4'h0, 3'h0, 2'h0, 8'h28);
        wait_st(4'h1, 10);
        wait_st(4'h4, 1500);
        go(1, 0, 3'h1, 4'h0, 3'h0, 2'h1, 8'h28);
        wait_st(4'h7, 3000);
        chk(saw_accel, 1'b0);
        go(1, 1, 3'h0, 4'h0, 3'h7, 2'h2, 8'h28);
        wait_st(4'h3, 3000);
        spin = 2'h0;
        wait_st(4'h6, 3000);
        go(1, 0, 3'h1, 4'h0, 3'h7, 2'h2, 8'h28);
        wait_st(4'h2, 3000);
        go(1, 1, 3'h0, 4'h0, 3'h0, 2'h2, 8'h04);
        bad = 0;
        repeat (3000) @(negedge sys_clk) bad += (seq_state !== 4'h1);
        chk(16'(bad), 16'h0000);
        summarize();
    end
endmodule // tb_start_sequencer
bind start_sequencer seq_checker chk_i (.sys_clk, .rstn, .speed_probe_enable,
    .reverse_drive_enable, .brake_duration_setting, .probe_current_threshold,
    .back_emf_constant_code, .seq_state, .drive_mode, .gate_drive, .back_emf_constant_value);
`default_nettype wire
